//--- hdl/interrupt_control_register.sv
`timescale 1ns/1ps
// Behaviour
// - Without priority mode, the global enable passes every enabled interrupt when 1 and blocks all when 0.
// - With priority mode, the global enable passes high-priority interrupts when 1 and blocks all when 0.
// - The timer-zero overflow request is forwarded only while bit 5 is set.
// - The external pin zero request is forwarded only while bit 4 is set.
// - The port-change request is forwarded only while bit 3 is set.
// - Bit 2 is set on timer-zero overflow and stays set until software writes it to zero.
// - Bit 0 is set while an upper port B pin has changed and is cleared by software.
// - Every flag is set by its source whatever the enables say.
module interrupt_control_register
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Interrupt sources
  input wire logic timer_zero_overflow_in,
  input wire logic external_interrupt_pin_zero_in,
  input wire logic [3:0] port_b_upper_nibble_pins_in,
  input wire logic periph_req_in,
  input wire logic periph_high_prio_in,
  // Requests toward the core
  output irq_ctl_pkg::irq_s irq_out
);
  import irq_ctl_pkg::*;

  // ==========================================
  // Bus address phase capture
  bus_phase_s phase_q;
  bus_phase_s phase_d;
  logic wr_ctl;
  logic wr_cfg;
  logic rd_port;

  // Capture a valid transfer of any size in its address phase
  always_comb
  begin
    phase_d = '0;
    if (hsel_in && hready_in && htrans_in[1])
    begin
      phase_d.valid = 1'b1;
      phase_d.write = hwrite_in;
      phase_d.addr = haddr_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      phase_q <= '0;
    else
      phase_q <= phase_d;
  end

  assign wr_ctl = phase_q.valid && phase_q.write && (phase_q.addr == ADDR_INTCTL);
  assign wr_cfg = phase_q.valid && phase_q.write && (phase_q.addr == ADDR_CONFIG);
  // Snapshot at the same edge that captures the pins as read data
  assign rd_port = phase_d.valid && !phase_d.write && (phase_d.addr == ADDR_PORT_READ);
  assign hreadyout_out = 1'b1;  // Zero wait states
  assign hresp_out = 1'b0;      // Always OKAY

  // ==========================================
  // Port change detector
  logic mismatch;
  logic [3:0] snapshot;

  port_change_detect u_detect
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .port_b_upper_nibble_pins_in(port_b_upper_nibble_pins_in),
    .snapshot_in(rd_port),
    .mismatch_out(mismatch),
    .snapshot_out(snapshot)
  );

  // ==========================================
  // Control register and priority mode
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic prio_q;
  logic prio_d;
  logic ext_q;
  logic ext_d;
  logic ext_rise;

  assign ext_rise = external_interrupt_pin_zero_in && !ext_q;

  // Enables written by software, flags set by hardware with set over clear
  always_comb
  begin
    ctl_d = ctl_q;
    prio_d = prio_q;
    ext_d = external_interrupt_pin_zero_in;
    if (wr_ctl)
      ctl_d = hwdata_in[7:0];
    if (wr_cfg)
      prio_d = hwdata_in[BIT_PRIO_MODE];
    if (timer_zero_overflow_in)
      ctl_d[BIT_TMR_FLAG] = 1'b1;
    if (ext_rise)
      ctl_d[BIT_EXT_FLAG] = 1'b1;
    if (mismatch)
      ctl_d[BIT_PORT_FLAG] = 1'b1;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctl_q <= INTCTL_RESET;
      prio_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      prio_q <= prio_d;
      ext_q <= ext_d;
    end
  end

  // ==========================================
  // Gating toward the core
  logic core_pend;
  logic glob;
  logic per;

  assign glob = ctl_q[BIT_GLOBAL];
  assign per = ctl_q[BIT_PERIPH];
  // Core sources: per-source enable and flag
  assign core_pend = (ctl_q[BIT_TMR_EN] && ctl_q[BIT_TMR_FLAG])
    || (ctl_q[BIT_EXT_EN] && ctl_q[BIT_EXT_FLAG])
    || (ctl_q[BIT_PORT_EN] && ctl_q[BIT_PORT_FLAG]);

  irq_s irq_d;
  always_comb
  begin
    irq_d = '0;
    if (!prio_q)
    begin
      irq_d.high_req = glob && (core_pend || (per && periph_req_in));
    end
    else
    begin
      // Core sources are high priority in priority mode
      irq_d.high_req = glob && (core_pend || (periph_req_in && periph_high_prio_in));
      irq_d.low_req = glob && per && periph_req_in && !periph_high_prio_in;
    end
  end

  irq_s irq_q;
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      irq_q <= '0;
    else
      irq_q <= irq_d;
  end
  assign irq_out = irq_q;

  // ==========================================
  // Read data
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (phase_d.valid && !phase_d.write)
    begin
      case (phase_d.addr)
        ADDR_INTCTL: rdata_d = {24'h00_0000, ctl_d};  // Sees a write still in its data phase
        ADDR_CONFIG: rdata_d = {31'h0000_0000, prio_d};  // Sees a write still in its data phase
        ADDR_STATUS: rdata_d = {30'h0000_0000, irq_q.low_req, irq_q.high_req};
        ADDR_PORT_READ: rdata_d = {28'h000_0000, port_b_upper_nibble_pins_in};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end
  assign hrdata_out = rdata_q;

  // ==========================================
  // Assertions
  property p_tmr_flag_set;
    @(posedge clk_in) disable iff (reset_in)
    timer_zero_overflow_in |=> ctl_q[BIT_TMR_FLAG];
  endproperty
  a_tmr_flag_set: assert property (p_tmr_flag_set) else $error("timer flag not set");

  property p_tmr_flag_hold;
    @(posedge clk_in) disable iff (reset_in)
    (ctl_q[BIT_TMR_FLAG] && !wr_ctl) |=> ctl_q[BIT_TMR_FLAG];
  endproperty
  a_tmr_flag_hold: assert property (p_tmr_flag_hold) else $error("timer flag cleared by itself");

  property p_port_flag_set;
    @(posedge clk_in) disable iff (reset_in)
    mismatch |=> ctl_q[BIT_PORT_FLAG];
  endproperty
  a_port_flag_set: assert property (p_port_flag_set) else $error("port flag not set");

  property p_ext_flag_set;
    @(posedge clk_in) disable iff (reset_in)
    (external_interrupt_pin_zero_in && !ext_q) |=> ctl_q[BIT_EXT_FLAG];
  endproperty
  a_ext_flag_set: assert property (p_ext_flag_set) else $error("ext flag not set");

  property p_global_off;
    @(posedge clk_in) disable iff (reset_in)
    !glob |=> !irq_q.high_req && !irq_q.low_req;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request while global off");

  property p_tmr_pass;
    @(posedge clk_in) disable iff (reset_in)
    (glob && ctl_q[BIT_TMR_EN] && ctl_q[BIT_TMR_FLAG]) |=> irq_q.high_req;
  endproperty
  a_tmr_pass: assert property (p_tmr_pass) else $error("timer request not passed");

  property p_low_blocked;
    @(posedge clk_in) disable iff (reset_in)
    (prio_q && !per) |=> !irq_q.low_req;
  endproperty
  a_low_blocked: assert property (p_low_blocked) else $error("low request while disabled");

  property p_ext_blocked;
    @(posedge clk_in) disable iff (reset_in)
    (ctl_q == 8'h82 && !periph_req_in) |=> !irq_q.high_req;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked) else $error("ext request passed");

  property p_port_blocked;
    @(posedge clk_in) disable iff (reset_in)
    (ctl_q == 8'h81 && !periph_req_in) |=> !irq_q.high_req;
  endproperty
  a_port_blocked: assert property (p_port_blocked) else $error("port request passed");

  property p_prio_low_only;
    @(posedge clk_in) disable iff (reset_in)
    (prio_q && glob && !per && !core_pend && periph_req_in && !periph_high_prio_in) |=> !irq_q.high_req;
  endproperty
  a_prio_low_only: assert property (p_prio_low_only) else $error("low source raised high");

  property p_tmr_flag_clear;
    @(posedge clk_in) disable iff (reset_in)
    (wr_ctl && !hwdata_in[BIT_TMR_FLAG] && !timer_zero_overflow_in) |=> !ctl_q[BIT_TMR_FLAG];
  endproperty
  a_tmr_flag_clear: assert property (p_tmr_flag_clear) else $error("timer flag not cleared");

  property p_port_flag_clear;
    @(posedge clk_in) disable iff (reset_in)
    (wr_ctl && !hwdata_in[BIT_PORT_FLAG] && !mismatch) |=> !ctl_q[BIT_PORT_FLAG];
  endproperty
  a_port_flag_clear: assert property (p_port_flag_clear) else $error("port flag set without change");

  property p_snapshot_taken;
    @(posedge clk_in) disable iff (reset_in)
    rd_port |=> (snapshot == $past(port_b_upper_nibble_pins_in));
  endproperty
  a_snapshot_taken: assert property (p_snapshot_taken) else $error("snapshot not taken on port read");

  property p_ext_pass;
    @(posedge clk_in) disable iff (reset_in)
    (glob && ctl_q[BIT_EXT_EN] && ctl_q[BIT_EXT_FLAG]) |=> irq_q.high_req;
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("ext request not passed");

  property p_port_pass;
    @(posedge clk_in) disable iff (reset_in)
    (glob && ctl_q[BIT_PORT_EN] && ctl_q[BIT_PORT_FLAG]) |=> irq_q.high_req;
  endproperty
  a_port_pass: assert property (p_port_pass) else $error("port request not passed");

  property p_periph_pass;
    @(posedge clk_in) disable iff (reset_in)
    (!prio_q && glob && per && periph_req_in) |=> irq_q.high_req;
  endproperty
  a_periph_pass: assert property (p_periph_pass) else $error("peripheral request not passed");

  property p_low_pass;
    @(posedge clk_in) disable iff (reset_in)
    (prio_q && glob && per && periph_req_in && !periph_high_prio_in) |=> irq_q.low_req;
  endproperty
  a_low_pass: assert property (p_low_pass) else $error("low request not passed");
endmodule // interrupt_control_register

//--- hdl/interrupt_enable_and_flag_pkg.sv
package irq_ctl_pkg;
  // ==========================================
  // Register map
  localparam logic [31:0] ADDR_INTCTL = 32'h0000_0000;
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_PORT_READ = 32'h0000_000c;
  // ==========================================
  // Field positions in the control register, and the priority mode bit of the config register
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_PERIPH = 6;
  localparam int BIT_TMR_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_PORT_EN = 3;
  localparam int BIT_TMR_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_PORT_FLAG = 0;
  localparam int BIT_PRIO_MODE = 0;
  // ==========================================
  // Reset values
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [3:0] SNAPSHOT_RESET = 4'h0;
  // ==========================================
  // Bus transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Interrupt requests toward the core
  typedef struct packed {
    logic high_req;
    logic low_req;
  } irq_s;

  // Latched address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } bus_phase_s;
endpackage

//--- hdl/port_change_detect.sv
`timescale 1ns/1ps
// ==========================================
// Port B upper nibble change detector
module port_change_detect
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Pins and snapshot control
  input wire logic [3:0] port_b_upper_nibble_pins_in,
  input wire logic snapshot_in,
  // Mismatch and snapshot
  output logic mismatch_out,
  output logic [3:0] snapshot_out
);
  import irq_ctl_pkg::*;

  logic [3:0] latch_q;
  logic [3:0] latch_d;
  logic [3:0] diff;

  // Per-pin comparison against the last read snapshot
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      assign diff[g] = port_b_upper_nibble_pins_in[g] ^ latch_q[g];
    end
  endgenerate

  // Reading the port ends the mismatch
  always_comb
  begin
    latch_d = latch_q;
    if (snapshot_in)
      latch_d = port_b_upper_nibble_pins_in;
  end

  // Snapshot register
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      latch_q <= SNAPSHOT_RESET;
    else
      latch_q <= latch_d;
  end

  assign mismatch_out = |diff;
  assign snapshot_out = latch_q;
endmodule // port_change_detect

//--- tb/core_model.sv
`timescale 1ns/1ps
// ==========================================
// Core side: keeps a record of every request offered
module core_model
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Requests from the block
  input wire irq_ctl_pkg::irq_s irq_in,
  // Sticky record, bit 0 high, bit 1 low
  output logic [1:0] seen_out
);
  import irq_ctl_pkg::*;
  // Collect requests until reset
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      seen_out <= 2'h0;
    else
      seen_out <= seen_out | {irq_in.low_req, irq_in.high_req};
  end
endmodule // core_model

//--- tb/testbench.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
module testbench;
  import irq_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic dp_pend = 1'b0;
  logic tov = 1'b0;
  logic ext = 1'b0;
  logic [3:0] pins = 4'h0;
  logic preq = 1'b0;
  logic phi = 1'b0;
  irq_s irq;
  logic [1:0] seen;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [3:0] rnd;
  logic [19:0] tbl [7] = '{20'h00c01, 20'h00800, 20'h10c02, 20'h10800, 20'h11801, 20'h11000, 20'h10400};
  int bad_count = 0;
  int n_compared = 0;

  // Design and core model
  interrupt_control_register i_interrupt_control_register (.clk_in(clk), .reset_in(rst),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(HSIZE_WORD),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .timer_zero_overflow_in(tov), .external_interrupt_pin_zero_in(ext),
    .port_b_upper_nibble_pins_in(pins), .periph_req_in(preq), .periph_high_prio_in(phi), .irq_out(irq));
  core_model i_core_model (.clk_in(clk), .reset_in(rst), .irq_in(irq), .seen_out(seen));

  // Clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  // ==========================================
  // Checking and closing
  task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compare each read data phase with the oldest note
  always @(posedge clk)
  begin
    if (rd_pend)
      cmp32(exp_q.pop_front(), hrdata);
    if (dp_pend)
      cmp32(32'h0, {31'h0, hresp});  // Always OKAY
    rd_pend = (hsel === 1'b1) && (htrans === HTRANS_NONSEQ) && (hwrite === 1'b0) && (hready === 1'b1);
    dp_pend = (hsel === 1'b1) && (htrans === HTRANS_NONSEQ) && (hready === 1'b1);
  end

  // ==========================================
  // Bus tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  // Write, then let the register and the request settle
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    step(2);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    rnd = 4'($urandom(32'h17baac28)) | 4'h1;
    step(2);
    rst <= 1'b0;
    step(1);
    // Reset values and an unmapped place
    rd(ADDR_INTCTL, {24'h0, INTCTL_RESET});
    rd(ADDR_STATUS, 32'h0);
    wr(32'h10, {rnd, 28'h0});
    rd(32'h10, 32'h0);
    $display("reset test done");
    // Timer flag with enables off, then gating
    tov <= 1'b1;
    step(1);
    tov <= 1'b0;
    step(3);
    rd(ADDR_INTCTL, 32'h04);
    rd(ADDR_STATUS, 32'h0);
    step(8);
    rd(ADDR_INTCTL, 32'h04);
    wr(ADDR_INTCTL, 32'ha4);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_INTCTL, 32'h24);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_INTCTL, 32'h84);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_INTCTL, 32'ha0);
    rd(ADDR_INTCTL, 32'ha0);
    $display("timer test done");
    // External pin edge
    wr(ADDR_INTCTL, 32'h90);
    ext <= 1'b1;
    step(3);
    rd(ADDR_INTCTL, 32'h92);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_INTCTL, 32'h82);
    rd(ADDR_STATUS, 32'h0);
    ext <= 1'b0;
    wr(ADDR_INTCTL, 32'h0);
    $display("pin test done");
    // Port change, snapshot and clear
    wr(ADDR_INTCTL, 32'h80);
    pins <= rnd;
    step(3);
    rd(ADDR_INTCTL, 32'h81);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_INTCTL, 32'h89);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_PORT_READ, {28'h0, rnd});
    wr(ADDR_INTCTL, 32'h88);
    rd(ADDR_INTCTL, 32'h88);
    rd(ADDR_STATUS, 32'h0);
    $display("port test done");
    // Global, peripheral and priority combinations from the table
    preq <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_CONFIG, {31'h0, tbl[i][16]});
      rd(ADDR_CONFIG, {31'h0, tbl[i][16]});
      phi <= tbl[i][12];
      wr(ADDR_INTCTL, {24'h0, tbl[i][11:4]});
      rd(ADDR_STATUS, {28'h0, tbl[i][3:0]});
    end
    preq <= 1'b0;
    step(3);
    cmp32(32'h3, {30'h0, seen});
    $display("priority test done");
    tally_and_finish();
  end
endmodule // testbench
